// *** hw/cmbi_pkg.sv ***
// Package with constants and types for the connection memory block initializer.
package cmbi_pkg;
	localparam logic [23:0] PATTERN_ADDR = 24'h040288;
	localparam logic [23:0] TRIGGER_ADDR = 24'h04028c;
	localparam logic [31:0] START_KEY = 32'h31415926;
	localparam logic [31:0] PATTERN_RESET = 32'h00000000;
	localparam int BUSY_BIT = 0;
	localparam int RESET_BIT = 1;
	localparam int FILL_TIME_NS = 120000;
	localparam int CLK_PERIOD_NS = 40;
	localparam int FILL_CYCLES = FILL_TIME_NS / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_FILL = 2'b10
	} cmbi_state_type;
	typedef struct packed {
		logic we;
		logic [14:0] addr;
		logic [31:0] data;
	} cmbi_mem_wr_type;
endpackage

// *** hw/cmbi_addr_seq.sv ***
// Address stepper that walks the connection memory once per start.
`timescale 1ns/1ps
`default_nettype none
module cmbi_addr_seq #(
	parameter int ADDR_W = 15
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic start,
	output logic active,
	output logic [ADDR_W-1:0] addr,
	output logic last
);
	logic [ADDR_W-1:0] addr_q;
	logic active_q;
	initial begin
		if (ADDR_W < 1 || ADDR_W > 24) $error("ADDR_W out of range");
	end
	assign last = active_q && (addr_q == {ADDR_W{1'b1}});
	assign active = active_q;
	assign addr = addr_q;
	// Walk addresses in order, stop right after the last one.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			active_q <= 1'b0;
			addr_q <= '0;
		end else if (active_q) begin
			addr_q <= addr_q + 1'b1;
			if (last) active_q <= 1'b0;
		end else if (start) begin
			active_q <= 1'b1;
			addr_q <= '0;
		end
	end
endmodule
`default_nettype wire

// *** hw/cmbi_top.sv ***
// Connection memory block initializer with its two host registers.
`timescale 1ns/1ps
`default_nettype none
module cmbi_top #(
	parameter int ADDR_W = 15
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic host_cs,
	input wire logic host_we,
	input wire logic [23:0] host_addr,
	input wire logic [31:0] host_wdata,
	output logic [31:0] host_rdata,
	input wire logic host_mem_access,
	output logic access_fault_signal,
	output cmbi_pkg::cmbi_mem_wr_type cm_wr,
	output logic tdm_out_en
);
	////////////////////////////////////////////////////////////////////////////////
	logic [31:0] pattern_q;
	logic [31:0] fill_data_q;
	logic reset_init_q;
	logic block_init_q;
	logic [31:0] rdata_q;
	logic seq_active;
	logic seq_last;
	logic [ADDR_W-1:0] seq_addr;
	cmbi_pkg::cmbi_state_type state_q;
	// The write port carries a 15-bit address, so a wider walk cannot be served.
	// A narrower walk is allowed and only shortens the fill, which helps simulation.
	initial begin
		if (ADDR_W < 1 || ADDR_W > 15) $error("ADDR_W out of range");
	end
	// Word decode ignores the two byte-lane bits of the host address.
	wire pat_hit = host_cs && host_addr[23:2] == cmbi_pkg::PATTERN_ADDR[23:2];
	wire trg_hit = host_cs && host_addr[23:2] == cmbi_pkg::TRIGGER_ADDR[23:2];
	wire key_ok = trg_hit && host_we && host_wdata == cmbi_pkg::START_KEY;
	// A start while filling is dropped, so the running fill completes unchanged.
	wire start = key_ok && state_q == cmbi_pkg::ST_IDLE;
	wire boot_start = reset_init_q && state_q == cmbi_pkg::ST_IDLE && !seq_active;
	wire go = start || boot_start;
	wire [31:0] status = {30'h0, reset_init_q, block_init_q};
	cmbi_addr_seq #(.ADDR_W(ADDR_W)) u_seq (
		.ref_clk(ref_clk),
		.reset(reset),
		.start(go),
		.active(seq_active),
		.addr(seq_addr),
		.last(seq_last)
	);
	// Pattern register; the fill uses its own latched copy.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pattern_q <= cmbi_pkg::PATTERN_RESET;
		end else if (pat_hit && host_we) begin
			pattern_q <= host_wdata;
		end
	end
	// Latch the pattern at start so later writes cannot corrupt the fill.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			fill_data_q <= '0;
		end else if (go) begin
			fill_data_q <= pattern_q;
		end
	end
	// Sequencer state and status flags; reset init runs once after reset.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q <= cmbi_pkg::ST_IDLE;
			reset_init_q <= 1'b1;
			block_init_q <= 1'b0;
		end else begin
			unique case (state_q)
				cmbi_pkg::ST_IDLE: begin
					if (go) begin
						state_q <= cmbi_pkg::ST_FILL;
						block_init_q <= 1'b1;
					end
				end
				cmbi_pkg::ST_FILL: begin
					if (seq_last) begin
						state_q <= cmbi_pkg::ST_IDLE;
						block_init_q <= 1'b0;
						reset_init_q <= 1'b0;
					end
				end
			endcase
		end
	end
	// Read data is registered; unmapped reads give zero.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdata_q <= '0;
		end else if (pat_hit) begin
			rdata_q <= pattern_q;
		end else if (trg_hit) begin
			rdata_q <= status;
		end else begin
			rdata_q <= '0;
		end
	end
	assign host_rdata = rdata_q;
	// Memory write stream; every location gets the latched pattern.
	assign cm_wr.we = state_q == cmbi_pkg::ST_FILL && seq_active;
	assign cm_wr.addr = 15'(seq_addr);
	assign cm_wr.data = fill_data_q;
	// Memory accesses fault while either init runs.
	assign access_fault_signal = host_mem_access && (block_init_q || reset_init_q);
	assign tdm_out_en = !block_init_q;
	////////////////////////////////////////////////////////////////////////////////
	// A key write in idle must start a fill on the next cycle.
	AST_KEY_STARTS: assert property (@(posedge ref_clk) disable iff (reset)
		state_q == cmbi_pkg::ST_IDLE && key_ok && !reset_init_q |=> block_init_q)
		else $error("Key write did not start fill");

	// Without a start the busy flag must stay low.
	AST_BAD_KEY: assert property (@(posedge ref_clk) disable iff (reset)
		state_q == cmbi_pkg::ST_IDLE && !go |=> !block_init_q)
		else $error("Fill started without key");

	// Fill data must not follow pattern writes made during a fill.
	AST_DATA_STABLE: assert property (@(posedge ref_clk) disable iff (reset)
		cm_wr.we && $past(cm_wr.we) |-> $stable(cm_wr.data))
		else $error("Fill data changed mid fill");

	// Consecutive memory writes must hit consecutive addresses.
	AST_ADDR_STEP: assert property (@(posedge ref_clk) disable iff (reset)
		cm_wr.we && $past(cm_wr.we) |-> cm_wr.addr == $past(cm_wr.addr) + 15'h1)
		else $error("Fill address not sequential");

	// Unused status bits must always read zero.
	AST_STATUS_ZERO: assert property (@(posedge ref_clk) disable iff (reset)
		$past(trg_hit) |-> host_rdata[31:2] == 30'h0)
		else $error("Status high bits nonzero");

	// Memory accesses fault during a block init.
	AST_FAULT: assert property (@(posedge ref_clk) disable iff (reset)
		host_mem_access && block_init_q |-> access_fault_signal)
		else $error("No bus error during init");

	// Memory accesses fault during the reset init as well.
	AST_FAULT_BOOT: assert property (@(posedge ref_clk) disable iff (reset)
		host_mem_access && reset_init_q |-> access_fault_signal)
		else $error("No bus error during reset init");

	// Outside both inits a memory access must not fault.
	AST_NO_FAULT: assert property (@(posedge ref_clk) disable iff (reset)
		!block_init_q && !reset_init_q |-> !access_fault_signal)
		else $error("Bus error outside init");

	// The serial outputs must be off while memory is being filled.
	AST_TRISTATE: assert property (@(posedge ref_clk) disable iff (reset)
		cm_wr.we |-> !tdm_out_en)
		else $error("Outputs driven during fill");

	// The serial outputs come back once no block init runs.
	AST_TDM_BACK: assert property (@(posedge ref_clk) disable iff (reset)
		!block_init_q |-> tdm_out_en)
		else $error("Outputs off outside fill");

	// Both progress flags drop right after the last location.
	AST_DONE: assert property (@(posedge ref_clk) disable iff (reset)
		seq_last |=> !block_init_q && !reset_init_q)
		else $error("Status not cleared after last");

	// Leaving reset must launch the boot fill.
	AST_BOOT: assert property (@(posedge ref_clk) $fell(reset) |-> ##1 block_init_q)
		else $error("No fill after reset");

	// A pattern write must land in the pattern register.
	AST_PAT_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
		pat_hit && host_we |=> pattern_q == $past(host_wdata))
		else $error("Pattern write lost");

	// A pattern read returns the stored pattern one cycle later.
	AST_PAT_READ: assert property (@(posedge ref_clk) disable iff (reset)
		pat_hit |=> host_rdata == $past(pattern_q))
		else $error("Pattern read wrong");

	// A trigger read returns the two progress flags.
	AST_STAT_READ: assert property (@(posedge ref_clk) disable iff (reset)
		trg_hit |=> host_rdata[1:0] == $past({reset_init_q, block_init_q}))
		else $error("Status read wrong");

	// A key during a running fill must not restart or reload it.
	AST_KEY_IGNORED: assert property (@(posedge ref_clk) disable iff (reset)
		key_ok && block_init_q && !seq_last |=> block_init_q && $stable(fill_data_q))
		else $error("Running fill disturbed by key");

	// Memory is written only while a block init runs.
	AST_WE_IN_FILL: assert property (@(posedge ref_clk) disable iff (reset)
		cm_wr.we |-> block_init_q)
		else $error("Memory written outside fill");

	// The first write of every fill goes to address zero.
	AST_FIRST_ADDR: assert property (@(posedge ref_clk) disable iff (reset)
		go |=> cm_wr.we && cm_wr.addr == 15'h0)
		else $error("Fill did not start at zero");

	// The fill carries the pattern held at the start edge.
	AST_PAT_LATCH: assert property (@(posedge ref_clk) disable iff (reset)
		go |=> cm_wr.data == $past(pattern_q))
		else $error("Fill data not latched at start");

	// The state register must always hold exactly one state.
	AST_ONEHOT: assert property (@(posedge ref_clk) disable iff (reset)
		$onehot(state_q))
		else $error("State not one-hot");

	// Main scenarios: boot fill, key start, ignored key, faults, mid-fill pattern write.
	COV_BOOT_DONE: cover property (@(posedge ref_clk) $fell(reset_init_q));
	COV_KEY_START: cover property (@(posedge ref_clk) start && !reset_init_q);
	COV_IGNORED: cover property (@(posedge ref_clk) key_ok && block_init_q);
	COV_FAULT: cover property (@(posedge ref_clk) access_fault_signal);
	COV_PAT_MID: cover property (@(posedge ref_clk) pat_hit && host_we && block_init_q);
endmodule
`default_nettype wire

// *** sim/cmbi_host.sv ***
// Host processor model that reaches the two initializer registers.
`timescale 1ns/1ps
`default_nettype none
module cmbi_host (
	input wire logic ref_clk,
	output logic host_cs,
	output logic host_we,
	output logic [23:0] host_addr,
	output logic [31:0] host_wdata,
	input wire logic [31:0] host_rdata
);
	initial begin
		host_cs = 1'b0;
		host_we = 1'b0;
		host_addr = 24'h0;
		host_wdata = 32'h0;
	end
	// One strobe per access; released lines are inverted so stale values never match.
	task acc(input logic w, input logic [23:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge ref_clk);
		host_cs <= 1'b1;
		host_we <= w;
		host_addr <= a;
		host_wdata <= d;
		@(posedge ref_clk);
		host_cs <= 1'b0;
		host_addr <= ~a;
		host_wdata <= ~d;
		#1 r = host_rdata;
	endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking testbench for the block initializer.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic ref_clk, reset, host_cs, host_we, host_mem_access, access_fault_signal, tdm_out_en;
	logic [23:0] host_addr;
	logic [31:0] host_wdata, host_rdata, pat, exp_pat, r;
	cmbi_pkg::cmbi_mem_wr_type cm_wr;
	int miscompares = 0, n_compared = 0, seed = 23464, nwr = 0;
	cmbi_top #(.ADDR_W(4)) cmbi_top_i (.ref_clk(ref_clk), .reset(reset), .host_cs(host_cs),
		.host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
		.host_rdata(host_rdata), .host_mem_access(host_mem_access),
		.access_fault_signal(access_fault_signal), .cm_wr(cm_wr), .tdm_out_en(tdm_out_en));
	cmbi_host cmbi_host_i (.ref_clk(ref_clk), .host_cs(host_cs), .host_we(host_we),
		.host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s exp=%h seen=%h", n, e, s);
		end
	endtask
	task end_sim;
		$display("compared=%0d mismatches=%0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Expected status word from the two progress flags.
	function automatic logic [31:0] stat(input logic b, input logic rs);
		return {30'h0, rs, b};
	endfunction
	// Poll status under a bounded count, since the fill length is the design's choice.
	task wait_idle;
		for (int i = 0; i < 60; i++) begin
			cmbi_host_i.acc(1'b0, cmbi_pkg::TRIGGER_ADDR, 32'h0, r);
			if (r[0] === 1'b0) return;
		end
		chk("idle", 32'h1, 32'h0);
	endtask
	// Every memory write must walk the addresses in order with the latched pattern.
	always @(posedge ref_clk) if (reset === 1'b0 && cm_wr.we === 1'b1) begin
		chk("cm_addr", {17'h0, cm_wr.addr}, nwr % 16);
		chk("cm_data", cm_wr.data, exp_pat);
		nwr++;
	end
	initial begin
		#200000;
		miscompares++;
		end_sim;
	end
	initial begin
		reset = 1'b1;
		host_mem_access = 1'b0;
		exp_pat = 32'h0;
		repeat (10) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (2) @(posedge ref_clk);
		host_mem_access <= 1'b1;
		#1 chk("fault_boot", access_fault_signal, 1);
		cmbi_host_i.acc(1'b0, cmbi_pkg::TRIGGER_ADDR, 32'h0, r);
		chk("boot_stat", r, stat(1, 1));
		wait_idle;
		chk("boot_writes", nwr, 16);
		chk("fault_idle", access_fault_signal, 0);
		cmbi_host_i.acc(1'b0, 24'h000100, 32'h0, r);
		chk("unmapped", r, 0);
		for (int k = 0; k < 3; k++) begin
			pat = $random(seed);
			cmbi_host_i.acc(1'b1, cmbi_pkg::PATTERN_ADDR, pat, r);
			cmbi_host_i.acc(1'b0, cmbi_pkg::PATTERN_ADDR, 32'h0, r);
			chk("pattern", r, pat);
			cmbi_host_i.acc(1'b1, cmbi_pkg::TRIGGER_ADDR, cmbi_pkg::START_KEY ^ (pat | 1), r);
			cmbi_host_i.acc(1'b0, cmbi_pkg::TRIGGER_ADDR, 32'h0, r);
			chk("nonkey", r, stat(0, 0));
			exp_pat = pat;
			nwr = 0;
			cmbi_host_i.acc(1'b1, cmbi_pkg::TRIGGER_ADDR, cmbi_pkg::START_KEY, r);
			cmbi_host_i.acc(1'b1, cmbi_pkg::PATTERN_ADDR, ~pat, r);
			cmbi_host_i.acc(1'b1, cmbi_pkg::TRIGGER_ADDR, cmbi_pkg::START_KEY, r);
			cmbi_host_i.acc(1'b0, cmbi_pkg::TRIGGER_ADDR, 32'h0, r);
			chk("busy", r, stat(1, 0));
			chk("tdm_off", tdm_out_en, 0);
			chk("fault_fill", access_fault_signal, 1);
			wait_idle;
			chk("fill_writes", nwr, 16);
			chk("tdm_on", tdm_out_en, 1);
		end
		end_sim;
	end
endmodule
`default_nettype wire
